// *** sirq_router.v ***
`timescale 1ns/1ps
`include "sirq_defines.vh"
module sirq_router #(
  parameter NUM_SRC = `SIRQ_NUM_SRC
) (
  input  wire                    i_clk,
  input  wire                    i_reset,
  input  wire [NUM_SRC-1:0]      i_event_flags,
  input  wire                    i_reg_wr,
  input  wire                    i_reg_rd,
  input  wire [`SIRQ_ADDR_W-1:0] i_reg_addr,
  input  wire [`SIRQ_DATA_W-1:0] i_reg_wdata,
  output reg  [`SIRQ_DATA_W-1:0] o_reg_rdata,
  output wire                    o_reg_hit,
  output wire                    o_irq_out_primary,
  output wire                    o_irq_out_primary_oe_n,
  output wire                    o_irq_out_secondary,
  output wire                    o_irq_out_secondary_oe_n
);
  ////////////////////////////////////////////////////////////////////////////
  reg  [`SIRQ_DATA_W-1:0] irq_pin_control_reg;
  reg  [`SIRQ_DATA_W-1:0] irq_source_enable_reg;
  reg  [`SIRQ_DATA_W-1:0] irq_pin_route_reg;
  reg  [`SIRQ_DATA_W-1:0] rdata_next;
  wire [NUM_SRC-1:0]      gated_flags;
  wire                    primary_active;
  wire                    secondary_active;
  wire                    sel_ctrl;
  wire                    sel_en;
  wire                    sel_route;

  assign sel_ctrl  = (i_reg_addr == `SIRQ_ADDR_PIN_CTRL);
  assign sel_en    = (i_reg_addr == `SIRQ_ADDR_SRC_EN);
  assign sel_route = (i_reg_addr == `SIRQ_ADDR_PIN_ROUTE);
  assign o_reg_hit = sel_ctrl | sel_en | sel_route;

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge i_clk) begin
    if (i_reset) begin
      irq_pin_control_reg   <= `SIRQ_RESET_VAL;
      irq_source_enable_reg <= `SIRQ_RESET_VAL;
      irq_pin_route_reg     <= `SIRQ_RESET_VAL;
    end else if (i_reg_wr) begin
      // reserved control bits are held at zero so they read back as zero
      if (sel_ctrl)
        irq_pin_control_reg <= i_reg_wdata & `SIRQ_CTRL_MASK;
      if (sel_en)
        irq_source_enable_reg <= i_reg_wdata;
      if (sel_route)
        irq_pin_route_reg <= i_reg_wdata;
    end
  end

  always @* begin
    rdata_next = o_reg_rdata;
    if (i_reg_rd) begin
      if (sel_ctrl)
        rdata_next = irq_pin_control_reg;
      else if (sel_en)
        rdata_next = irq_source_enable_reg;
      else if (sel_route)
        rdata_next = irq_pin_route_reg;
      else
        rdata_next = `SIRQ_RESET_VAL;
    end
  end

  always @(posedge i_clk) begin
    if (i_reset)
      o_reg_rdata <= `SIRQ_RESET_VAL;
    else
      o_reg_rdata <= rdata_next;
  end

  ////////////////////////////////////////////////////////////////////////////
  // bit positions of the flags match the enable bits one to one,
  // so bit 7 data ready, 6 fifo, 5/4 window, 3/2 threshold, 1/0 change
  assign gated_flags = i_event_flags & irq_source_enable_reg[NUM_SRC-1:0];
  assign primary_active   = |(gated_flags & irq_pin_route_reg[NUM_SRC-1:0]);
  assign secondary_active = |(gated_flags & ~irq_pin_route_reg[NUM_SRC-1:0]);
  // the host must still read the source flags; pins carry no source identity

  ////////////////////////////////////////////////////////////////////////////
  sirq_pin_drive u_primary (
    .i_clk        (i_clk),
    .i_reset      (i_reset),
    .i_active     (primary_active),
    .i_polarity   (irq_pin_control_reg[`SIRQ_BIT_POL1]),
    .i_open_drain (irq_pin_control_reg[`SIRQ_BIT_OD1]),
    .o_pin        (o_irq_out_primary),
    .o_pin_oe_n   (o_irq_out_primary_oe_n)
  );

  sirq_pin_drive u_secondary (
    .i_clk        (i_clk),
    .i_reset      (i_reset),
    .i_active     (secondary_active),
    .i_polarity   (irq_pin_control_reg[`SIRQ_BIT_POL2]),
    .i_open_drain (irq_pin_control_reg[`SIRQ_BIT_OD2]),
    .o_pin        (o_irq_out_secondary),
    .o_pin_oe_n   (o_irq_out_secondary_oe_n)
  );
endmodule

// *** sirq_defines.vh ***
`ifndef SIRQ_DEFINES_VH
`define SIRQ_DEFINES_VH
`define SIRQ_ADDR_W          8
`define SIRQ_DATA_W          8
`define SIRQ_NUM_SRC         8
`define SIRQ_ADDR_PIN_CTRL   8'h28
`define SIRQ_ADDR_SRC_EN     8'h29
`define SIRQ_ADDR_PIN_ROUTE  8'h2a
`define SIRQ_RESET_VAL       8'h00
`define SIRQ_CTRL_MASK       8'h33
`define SIRQ_BIT_DRDY        7
`define SIRQ_BIT_FIFO        6
`define SIRQ_BIT_PW          5
`define SIRQ_BIT_TW          4
`define SIRQ_BIT_PTH         3
`define SIRQ_BIT_TTH         2
`define SIRQ_BIT_PCHG        1
`define SIRQ_BIT_TCHG        0
`define SIRQ_BIT_POL1        5
`define SIRQ_BIT_OD1         4
`define SIRQ_BIT_POL2        1
`define SIRQ_BIT_OD2         0
`endif

// *** sirq_pin_drive.v ***
`timescale 1ns/1ps
module sirq_pin_drive (
  input  wire i_clk,
  input  wire i_reset,
  input  wire i_active,
  input  wire i_polarity,
  input  wire i_open_drain,
  output reg  o_pin,
  output reg  o_pin_oe_n
);
  reg level;
  reg oe_n;
  always @* begin
    level = i_active ? i_polarity : ~i_polarity;
    // open drain only pulls low; a high level is released to the pull-up
    oe_n = i_open_drain ? level : 1'h0;
  end
  // registered so the pad never sees decode glitches
  always @(posedge i_clk) begin
    if (i_reset) begin
      o_pin      <= 1'h1;
      o_pin_oe_n <= 1'h0;
    end else begin
      o_pin      <= i_open_drain ? 1'h0 : level;
      o_pin_oe_n <= oe_n;
    end
  end
endmodule

// *** sirq_host.sv ***
`timescale 1ns/1ps
module sirq_host (
  input  wire o_irq_out_primary, o_irq_out_primary_oe_n,
  input  wire o_irq_out_secondary, o_irq_out_secondary_oe_n,
  output wire line1, line2
);
  // released line reads the pull-up, never the last level
  assign line1 = o_irq_out_primary_oe_n | o_irq_out_primary;
  assign line2 = o_irq_out_secondary_oe_n | o_irq_out_secondary;
endmodule

// *** sirq_properties.sv ***
`timescale 1ns/1ps
module sirq_props (
  input wire i_clk, i_reset, i_reg_wr, i_reg_rd, o_reg_hit,
  input wire o_irq_out_primary, o_irq_out_primary_oe_n,
  input wire o_irq_out_secondary, o_irq_out_secondary_oe_n,
  input wire [7:0] i_event_flags, i_reg_addr, i_reg_wdata, o_reg_rdata
);
  reg  [7:0] c, e, r;
  reg  [3:0] x;
  wire [7:0] a = i_reg_addr;
  wire       h = a >= 8'h28 && a <= 8'h2a;
  wire [7:0] v = a == 8'h28 ? c : a == 8'h29 ? e : h ? r : 8'h00;
  wire       l1 = |(i_event_flags & e & r) ~^ c[5];
  wire       l2 = |(i_event_flags & e & ~r) ~^ c[1];
  // pins lag by one edge, so the forecast is registered too
  always @(posedge i_clk) begin
    x <= i_reset ? 4'ha : {~c[4] & l1, c[4] & l1, ~c[0] & l2, c[0] & l2};
    c <= i_reset ? 8'h00 : i_reg_wr && a == 8'h28 ? i_reg_wdata & 8'h33 : c;
    e <= i_reset ? 8'h00 : i_reg_wr && a == 8'h29 ? i_reg_wdata : e;
    r <= i_reset ? 8'h00 : i_reg_wr && a == 8'h2a ? i_reg_wdata : r;
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);
  AST_HIT: assert property (o_reg_hit == h) else $error("hit");
  AST_P1: assert property (o_irq_out_primary == x[3]) else $error("p1");
  AST_O1: assert property (o_irq_out_primary_oe_n == x[2])
    else $error("oe1");
  AST_P2: assert property (o_irq_out_secondary == x[1])
    else $error("p2");
  AST_O2: assert property (o_irq_out_secondary_oe_n == x[0])
    else $error("oe2");
  AST_RD: assert property (i_reg_rd |=> o_reg_rdata == $past(v))
    else $error("rd");
  AST_HOLD: assert property (!i_reg_rd |=> $stable(o_reg_rdata))
    else $error("hold");
  AST_RST: assert property ($fell(i_reset) |-> o_reg_rdata == 8'h00)
    else $error("rst");
endmodule
bind sirq_router sirq_props i_props (.*);

// *** tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
  reg        i_clk = 0, i_reset = 1, i_reg_wr = 0, i_reg_rd = 0;
  reg  [7:0] i_event_flags = 0, i_reg_addr = 0, i_reg_wdata = 0;
  wire [7:0] o_reg_rdata;
  wire       o_reg_hit, o_irq_out_primary, o_irq_out_primary_oe_n;
  wire       o_irq_out_secondary, o_irq_out_secondary_oe_n, line1, line2;
  integer    bad_count = 0, check_count = 0, cyc = 0, i;
  sirq_router i_dut (.*);
  sirq_host   i_host (.*);
  initial forever #50 i_clk = ~i_clk;
  task check(input [7:0] s, x);
    check_count++;
    if (s !== x) begin
      bad_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, x);
    end
  endtask
  task acc(input w, input [7:0] a, d);
    @(posedge i_clk);
    {i_reg_wr, i_reg_rd, i_reg_addr, i_reg_wdata} <= {w, !w, a, d};
    @(posedge i_clk);
    {i_reg_wr, i_reg_rd} <= 2'h0;
    #1 if (!w) check(o_reg_rdata, d);
  endtask
  // pins are registered, so two edges cover the flag and the pin update
  task fl(input [7:0] f, input [1:0] p);
    @(posedge i_clk);
    i_event_flags <= f;
    repeat (2) @(posedge i_clk);
    #1 check({line1, line2}, p);
  endtask
  task s_reset;
    for (i = 0; i < 4; i++) acc(0, 8'h28 + i[7:0], 8'h00);
  endtask
  task s_route;
    acc(1, 8'h2a, 8'haa);
    fl(8'hff, 2'h3);
    for (i = 0; i < 8; i++) begin
      acc(1, 8'h29, 8'h01 << i);
      fl(8'hff, i[0] ? 2'h1 : 2'h2);
    end
  endtask
  task s_or;
    acc(1, 8'h29, 8'hff);
    acc(1, 8'h2a, 8'h0f);
    acc(0, 8'h2a, 8'h0f);
    fl(8'h30, 2'h2);
    fl(8'h81, 2'h0);
    fl(8'h00, 2'h3);
  endtask
  task s_pol;
    acc(1, 8'h28, 8'hff);
    acc(0, 8'h28, 8'h33);
    fl(8'h03, 2'h2);
    check({o_irq_out_primary_oe_n, o_irq_out_secondary_oe_n}, 8'h02);
  endtask
  // push-pull active high and open-drain active low were otherwise never set
  task s_mode;
    acc(1, 8'h28, 8'h22);
    acc(0, 8'h29, 8'hff);
    fl(8'h81, 2'h3);
    fl(8'h10, 2'h1);
    check({o_irq_out_primary_oe_n, o_irq_out_secondary_oe_n}, 8'h00);
    acc(1, 8'h28, 8'h11);
    fl(8'h01, 2'h1);
    check({o_irq_out_primary, o_irq_out_secondary}, 8'h00);
    check({o_irq_out_primary_oe_n, o_irq_out_secondary_oe_n}, 8'h01);
  endtask
  // mid-run reset must clear registers that now hold non-zero values
  task s_rerst;
    @(posedge i_clk);
    {i_reset, i_event_flags} <= {1'h1, 8'hff};
    repeat (2) @(posedge i_clk);
    i_reset <= 1'h0;
    fl(8'hff, 2'h3);
    check({o_irq_out_primary_oe_n, o_irq_out_secondary_oe_n}, 8'h00);
    s_reset;
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 1000) begin
      bad_count++;
      complete_run;
    end
  end
  initial begin
    repeat (16) @(posedge i_clk);
    i_reset <= 1'b0;
    s_reset;
    s_route;
    s_or;
    s_pol;
    s_mode;
    s_rerst;
    complete_run;
  end
endmodule
